// file: hdl/hbp_dpram.sv
`timescale 1ns/1ps
// Host-side word memory with registered read data
module hbp_dpram (
  input  wire logic                           sys_clk,
  input  wire logic [hbp_pkg::RAM_AW-1:0]     addr,
  input  wire logic                           wr_lo,
  input  wire logic                           wr_hi,
  input  wire logic [hbp_pkg::DATA_W-1:0]     wdata,
  output logic      [hbp_pkg::DATA_W-1:0]     rdata
);
  logic [hbp_pkg::DATA_W-1:0] mem [0:(1<<hbp_pkg::RAM_AW)-1];

  always_ff @(posedge sys_clk) begin
    if (wr_lo) begin
      mem[addr][7:0] <= wdata[7:0];
    end
    if (wr_hi) begin
      mem[addr][15:8] <= wdata[15:8];
    end
    rdata <= mem[addr];
  end
endmodule

// file: hdl/hbp_host_port.sv
`timescale 1ns/1ps
module hbp_host_port (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Straps
  input  wire logic        data_width_strap,
  input  wire logic        muxed_addr_strap,
  input  wire logic        strobe_style_strap,
  input  wire logic        strobe_polarity_strap,
  input  wire logic        byte_order_strap,
  input  wire logic        baud_hi_legacy_strap,
  input  wire logic        baud_lo_strap,
  // Host bus
  input  wire logic        addr_latch_en_low_byte,
  input  wire logic        addr_latch_en_high_byte,
  input  wire logic        read_or_data_strobe,
  input  wire logic        write_or_direction,
  input  wire logic        upper_lane_enable_n,
  input  wire logic        ram_select_a_n,
  input  wire logic        ram_select_b_n,
  input  wire logic        periph_select_n,
  input  wire logic        periph_select_p,
  input  wire logic [15:0] addr_in,
  output logic      [15:0] addr_out,
  output logic      [15:0] addr_oe_n,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic      [15:0] data_oe_n,
  output logic             ram_collision_n,
  // DMA
  output logic             rx_fifo_dma_req,
  input  wire logic        rx_fifo_dma_ack_n,
  output logic             tx_fifo_dma_req,
  input  wire logic        tx_fifo_dma_ack_n,
  // Core side
  input  wire logic        core_ram_active,
  input  wire logic [10:0] core_ram_addr,
  input  wire logic        rx_push,
  input  wire logic [15:0] rx_push_data,
  input  wire logic        tx_pop,
  output logic      [15:0] tx_pop_data_ff,
  output logic             tx_pop_valid_ff,
  input  wire logic [3:0]  irq_sources,
  output logic             irq_out_a,
  output logic             irq_out_b,
  output logic      [1:0]  baud_sel_ff,
  output logic             legacy_mode_ff
);
  hbp_pkg::hbp_state_t state_ff;
  hbp_pkg::hbp_state_t nxt_state;
  logic [15:0] alat_ff;
  logic [15:0] addr;
  logic        rd_strobe;
  logic        wr_strobe;
  logic        cycle_act;
  logic        ram_sel;
  logic        reg_sel;
  logic        rx_dma;
  logic        tx_dma;
  logic        lane_lo;
  logic        lane_hi;
  logic [15:0] wr_word;
  logic [15:0] ram_rdata;
  logic        ram_wr_lo;
  logic        ram_wr_hi;
  logic [15:0] ctrl_ff;
  logic [15:0] irqa_ff;
  logic [15:0] irqb_ff;
  logic [15:0] rx_mem [0:hbp_pkg::FIFO_DEPTH-1];
  logic [15:0] tx_mem [0:hbp_pkg::FIFO_DEPTH-1];
  logic [3:0]  rx_cnt_ff;
  logic [3:0]  tx_cnt_ff;
  logic [2:0]  rx_rp_ff;
  logic [2:0]  rx_wp_ff;
  logic [2:0]  tx_rp_ff;
  logic [2:0]  tx_wp_ff;
  logic        rx_pop;
  logic        tx_push;
  logic        rd_cycle;
  logic        wr_cycle;
  logic [15:0] rd_word;
  logic [15:0] reg_rdata;
  logic [15:0] rx_hold_ff;
  logic        ram_hit;

  // Address latch, transparent while enable high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alat_ff <= 16'h0000;
    end else begin
      if (muxed_addr_strap && addr_latch_en_low_byte) begin
        alat_ff[7:0] <= data_in[7:0];
      end
      if (muxed_addr_strap && addr_latch_en_high_byte) begin
        alat_ff[15:8] <= data_in[15:8];
      end
    end
  end

  // Open latch passes data straight through
  always_comb begin
    addr = muxed_addr_strap ? alat_ff : addr_in;
    if (muxed_addr_strap && addr_latch_en_low_byte) begin
      addr[7:0] = data_in[7:0];
    end
    if (muxed_addr_strap && addr_latch_en_high_byte) begin
      addr[15:8] = data_in[15:8];
    end
  end

  // Strobe decode
  always_comb begin
    if (!strobe_style_strap) begin
      rd_strobe = !read_or_data_strobe;
      wr_strobe = !write_or_direction;
    end else begin
      cycle_act = (read_or_data_strobe == strobe_polarity_strap);
      rd_strobe = cycle_act && write_or_direction;
      wr_strobe = cycle_act && !write_or_direction;
    end
    cycle_act = rd_strobe || wr_strobe;
  end

  assign rx_dma  = !rx_fifo_dma_ack_n;
  assign tx_dma  = !tx_fifo_dma_ack_n;
  assign ram_sel = !ram_select_a_n && !ram_select_b_n && !rx_dma && !tx_dma;
  assign reg_sel = !periph_select_n && periph_select_p && !rx_dma && !tx_dma;

  // Byte lane choice
  always_comb begin
    if (!data_width_strap) begin
      lane_lo = (addr[0] == byte_order_strap);
      lane_hi = !lane_lo;
      wr_word = {data_in[7:0], data_in[7:0]};
    end else begin
      lane_lo = 1'b1;
      lane_hi = !upper_lane_enable_n;
      wr_word = data_in;
      if (byte_order_strap) begin
        wr_word = {data_in[7:0], data_in[15:8]};
      end
    end
  end

  // One action per strobe, taken on its first cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hbp_pkg::HBP_IDLE: begin
        if (cycle_act) begin
          nxt_state = hbp_pkg::HBP_ACCESS;
        end
      end
      hbp_pkg::HBP_ACCESS: begin
        nxt_state = cycle_act ? hbp_pkg::HBP_DONE : hbp_pkg::HBP_IDLE;
      end
      hbp_pkg::HBP_DONE: begin
        if (!cycle_act) begin
          nxt_state = hbp_pkg::HBP_IDLE;
        end
      end
      default: nxt_state = hbp_pkg::HBP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= hbp_pkg::HBP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_cycle  = rd_strobe && state_ff == hbp_pkg::HBP_IDLE;
  assign wr_cycle  = wr_strobe && state_ff == hbp_pkg::HBP_IDLE;
  assign rx_pop    = rd_cycle && rx_dma && rx_cnt_ff != 4'h0;
  assign tx_push   = wr_cycle && tx_dma && tx_cnt_ff != 4'h8;
  // Busy output lags a cycle, so the write gate looks at the hit itself
  assign ram_hit   = ram_sel && core_ram_active && core_ram_addr == addr[11:1];
  assign ram_wr_lo = wr_cycle && ram_sel && lane_lo && !ram_hit;
  assign ram_wr_hi = wr_cycle && ram_sel && lane_hi && !ram_hit;

  hbp_dpram u_ram (
    .sys_clk (sys_clk),
    .addr    (addr[11:1]),
    .wr_lo   (ram_wr_lo),
    .wr_hi   (ram_wr_hi),
    .wdata   (wr_word),
    .rdata   (ram_rdata)
  );

  // Receive FIFO, filled by the core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_ff <= 4'h0;
      rx_rp_ff  <= 3'h0;
      rx_wp_ff  <= 3'h0;
      rx_hold_ff <= 16'h0000;
    end else begin
      if (rx_push && rx_cnt_ff != 4'h8) begin
        rx_mem[rx_wp_ff] <= rx_push_data;
        rx_wp_ff <= rx_wp_ff + 3'h1;
      end
      if (rx_pop) begin
        rx_rp_ff <= rx_rp_ff + 3'h1;
        rx_hold_ff <= rx_mem[rx_rp_ff];
      end
      rx_cnt_ff <= rx_cnt_ff + {3'h0, rx_push && rx_cnt_ff != 4'h8} - {3'h0, rx_pop};
    end
  end

  // Transmit FIFO, drained by the core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_ff       <= 4'h0;
      tx_rp_ff        <= 3'h0;
      tx_wp_ff        <= 3'h0;
      tx_pop_valid_ff <= 1'b0;
      tx_pop_data_ff  <= 16'h0000;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_ff] <= wr_word;
        tx_wp_ff <= tx_wp_ff + 3'h1;
      end
      tx_pop_valid_ff <= tx_pop && tx_cnt_ff != 4'h0;
      if (tx_pop && tx_cnt_ff != 4'h0) begin
        tx_pop_data_ff <= tx_mem[tx_rp_ff];
        tx_rp_ff <= tx_rp_ff + 3'h1;
      end
      tx_cnt_ff <= tx_cnt_ff + {3'h0, tx_push} - {3'h0, tx_pop && tx_cnt_ff != 4'h0};
    end
  end

  // Drop early when the last word moves
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_fifo_dma_req <= 1'b0;
      tx_fifo_dma_req <= 1'b0;
    end else begin
      rx_fifo_dma_req <= (rx_cnt_ff != 4'h0) && !(rx_cnt_ff == 4'h1 && rx_pop);
      tx_fifo_dma_req <= (tx_cnt_ff != 4'h8) && !(tx_cnt_ff == 4'h7 && tx_push);
    end
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= hbp_pkg::CTRL_RST;
      irqa_ff <= hbp_pkg::IRQ_RST;
      irqb_ff <= hbp_pkg::IRQ_RST;
    end else if (wr_cycle && reg_sel) begin
      if (addr[6:1] == hbp_pkg::REG_CTRL) begin
        ctrl_ff <= wr_word;
      end else if (addr[6:1] == hbp_pkg::REG_IRQ_A) begin
        irqa_ff <= wr_word;
      end else if (addr[6:1] == hbp_pkg::REG_IRQ_B) begin
        irqb_ff <= wr_word;
      end
    end
  end

  always_comb begin
    reg_rdata = 16'h0000;
    if (addr[6:1] == hbp_pkg::REG_CTRL) begin
      reg_rdata = ctrl_ff;
    end else if (addr[6:1] == hbp_pkg::REG_IRQ_A) begin
      reg_rdata = irqa_ff;
    end else if (addr[6:1] == hbp_pkg::REG_IRQ_B) begin
      reg_rdata = irqb_ff;
    end else if (addr[6:1] == hbp_pkg::REG_STATUS) begin
      reg_rdata = {rx_cnt_ff, tx_cnt_ff, 5'h00, legacy_mode_ff, baud_sel_ff};
    end
  end

  // Source for read data, FIFO first
  always_comb begin
    rd_word = 16'h0000;
    if (rx_dma) begin
      // Popped word must stand for the whole strobe
      rd_word = (state_ff == hbp_pkg::HBP_IDLE) ? rx_mem[rx_rp_ff] : rx_hold_ff;
    end else if (reg_sel) begin
      rd_word = reg_rdata;
    end else if (ram_sel) begin
      rd_word = ram_rdata;
    end
  end

  // Data bus drive; RAM data lags one cycle behind the address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out  <= 16'h0000;
      data_oe_n <= 16'hFFFF;
      addr_out  <= 16'h0000;
      addr_oe_n <= 16'hFFFF;
    end else begin
      addr_out  <= addr;
      addr_oe_n <= muxed_addr_strap ? 16'h0000 : 16'hFFFF;
      data_oe_n <= 16'hFFFF;
      if (rd_strobe && (rx_dma || reg_sel || ram_sel)) begin
        if (!data_width_strap) begin
          data_out  <= {8'h00, lane_lo ? rd_word[7:0] : rd_word[15:8]};
          data_oe_n <= 16'hFF00;
        end else begin
          data_out  <= byte_order_strap ? {rd_word[7:0], rd_word[15:8]} : rd_word;
          data_oe_n <= {{8{upper_lane_enable_n}}, 8'h00};
        end
      end
    end
  end

  // Collision while the core touches the same word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_collision_n <= 1'b1;
    end else begin
      ram_collision_n <= !(cycle_act && ram_hit);
    end
  end

  // Interrupts: low bits pick sources, top bit is polarity
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out_a <= 1'b0;
      irq_out_b <= 1'b0;
    end else begin
      irq_out_a <= (|(irqa_ff[3:0] & irq_sources)) ~^ irqa_ff[hbp_pkg::IRQ_POL_BIT];
      irq_out_b <= (|(irqb_ff[3:0] & irq_sources)) ~^ irqb_ff[hbp_pkg::IRQ_POL_BIT];
    end
  end

  // Baud selection with software override of the low strap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_sel_ff    <= 2'h0;
      legacy_mode_ff <= 1'b0;
    end else begin
      baud_sel_ff[1] <= baud_hi_legacy_strap;
      baud_sel_ff[0] <= ctrl_ff[hbp_pkg::CTRL_BAUD_OVR_EN] ? ctrl_ff[hbp_pkg::CTRL_BAUD_OVR] : baud_lo_strap;
      legacy_mode_ff <= baud_hi_legacy_strap;
    end
  end

  rx_req_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_cnt_ff == 4'h0 |=> !rx_fifo_dma_req) else $error("rx request with empty fifo");
  tx_req_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_cnt_ff == 4'h8 |=> !tx_fifo_dma_req) else $error("tx request with full fifo");
  tx_push_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_push && !(tx_pop && tx_cnt_ff != 4'h0) |=> tx_cnt_ff == $past(tx_cnt_ff) + 4'h1)
    else $error("tx write lost");
  busy_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cycle_act && ram_sel && core_ram_active && core_ram_addr == addr[11:1] |=> !ram_collision_n)
    else $error("collision not flagged");
  ram_nowr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ram_select_a_n || ram_select_b_n) |-> !ram_wr_lo && !ram_wr_hi) else $error("ram write unselected");
  addr_drv_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !muxed_addr_strap |=> addr_oe_n == 16'hFFFF) else $error("address driven unmuxed");
  narrow_lane_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !data_width_strap |=> data_oe_n[15:8] == 8'hFF) else $error("upper lane in 8-bit mode");
  legacy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    baud_hi_legacy_strap [*2] |-> legacy_mode_ff) else $error("legacy mode missing");
endmodule

// file: shared/hbp_pkg.sv
package hbp_pkg;
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 16;
  localparam int RAM_AW      = 11;
  localparam int FIFO_AW     = 3;
  localparam int FIFO_DEPTH  = 8;
  localparam int REG_AW      = 6;
  localparam int IRQ_SRC_W   = 4;
  // Register index (address bits 6..1)
  localparam logic [5:0] REG_CTRL    = 6'h00;
  localparam logic [5:0] REG_IRQ_A   = 6'h01;
  localparam logic [5:0] REG_IRQ_B   = 6'h02;
  localparam logic [5:0] REG_STATUS  = 6'h03;
  localparam logic [5:0] REG_RXDATA  = 6'h04;
  localparam logic [5:0] REG_TXDATA  = 6'h05;
  // Control and interrupt register fields
  localparam int CTRL_BAUD_OVR_EN = 0;
  localparam int CTRL_BAUD_OVR    = 1;
  localparam int IRQ_POL_BIT      = 15;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] IRQ_RST  = 16'h0000;
  typedef enum logic [1:0] {HBP_IDLE, HBP_ACCESS, HBP_DONE} hbp_state_t;
endpackage

// file: testbench/hbp_host_model.sv
`timescale 1ns/1ps
// Host processor and DMA controller, one access per call, up to three for a write that sees a collision
module hbp_host_model (
  input  wire logic        sys_clk,
  input  wire logic        strobe_style_strap,
  input  wire logic        strobe_polarity_strap,
  input  wire logic        muxed_addr_strap,
  input  wire logic        ram_collision_n,
  input  wire logic [15:0] data_in,
  output logic             addr_latch_en_low_byte,
  output logic             addr_latch_en_high_byte,
  output logic             read_or_data_strobe,
  output logic             write_or_direction,
  output logic             ram_select_a_n,
  output logic             ram_select_b_n,
  output logic             periph_select_n,
  output logic             periph_select_p,
  output logic             rx_fifo_dma_ack_n,
  output logic             tx_fifo_dma_ack_n,
  output logic      [15:0] host_a,
  output logic      [15:0] host_d
);
  logic saw_busy;

  initial begin
    {addr_latch_en_low_byte, addr_latch_en_high_byte, read_or_data_strobe, write_or_direction} = '1;
    {ram_select_a_n, ram_select_b_n, periph_select_n, rx_fifo_dma_ack_n, tx_fifo_dma_ack_n} = '1;
    {periph_select_p, saw_busy, host_a, host_d} = '0;
  end

  task automatic idle();
    read_or_data_strobe <= strobe_style_strap ? !strobe_polarity_strap : 1'b1;
    {write_or_direction, ram_select_a_n, ram_select_b_n, periph_select_n} <= '1;
    {rx_fifo_dma_ack_n, tx_fifo_dma_ack_n} <= '1;
    {addr_latch_en_low_byte, addr_latch_en_high_byte} <= {2{!muxed_addr_strap}};
    periph_select_p <= 1'b0;
    // Released lines must not keep the last value
    host_d <= ~host_d;
  endtask

  // k: 0 ram, 1 regs, 2 none, 3 rx dma, 4 tx dma, 5 one ram select
  task automatic access(input logic wr, input int k, input logic [15:0] a, input logic [15:0] wd,
                        output logic [15:0] rd);
    int n;
    n = 0;
    do begin
      saw_busy = 1'b0;
      @(posedge sys_clk);
      if (muxed_addr_strap) begin
        host_d <= a;
        {addr_latch_en_low_byte, addr_latch_en_high_byte} <= 2'b11;
        @(posedge sys_clk);
        {addr_latch_en_low_byte, addr_latch_en_high_byte} <= 2'b00;
        @(posedge sys_clk);
      end
      host_a <= muxed_addr_strap ? ~a : a;
      host_d <= wr ? wd : ~wd;
      ram_select_a_n <= !(k == 0 || k == 5);
      ram_select_b_n <= k != 0;
      periph_select_n <= k != 1;
      periph_select_p <= k == 1;
      rx_fifo_dma_ack_n <= k != 3;
      tx_fifo_dma_ack_n <= k != 4;
      if (strobe_style_strap) begin
        write_or_direction <= !wr;
        read_or_data_strobe <= strobe_polarity_strap;
      end else if (wr) begin
        write_or_direction <= 1'b0;
      end else begin
        read_or_data_strobe <= 1'b0;
      end
      // RAM data needs the strobe held three cycles
      repeat (3) begin
        @(negedge sys_clk);
        if (ram_collision_n === 1'b0) saw_busy = 1'b1;
      end
      rd = data_in;
      @(posedge sys_clk);
      idle();
      n++;
    end while (wr && saw_busy && n < 3);
  endtask
endmodule

// file: testbench/host_bus_and_dma_port_bench.sv
`timescale 1ns/1ps
module host_bus_and_dma_port_bench;
  logic        sys_clk, rst_n, data_width_strap, muxed_addr_strap, strobe_style_strap;
  logic        strobe_polarity_strap, byte_order_strap, baud_hi_legacy_strap, baud_lo_strap;
  logic        addr_latch_en_low_byte, addr_latch_en_high_byte, read_or_data_strobe, write_or_direction;
  logic        upper_lane_enable_n, ram_select_a_n, ram_select_b_n, periph_select_n, periph_select_p;
  logic        ram_collision_n, rx_fifo_dma_req, rx_fifo_dma_ack_n, tx_fifo_dma_req, tx_fifo_dma_ack_n;
  logic        core_ram_active, rx_push, tx_pop, tx_pop_valid_ff, irq_out_a, irq_out_b, legacy_mode_ff;
  logic [15:0] addr_in, addr_out, addr_oe_n, data_in, data_out, data_oe_n, rx_push_data, tx_pop_data_ff;
  logic [15:0] host_a, host_d, rdv;
  logic [10:0] core_ram_addr;
  logic [3:0]  irq_sources;
  logic [1:0]  baud_sel_ff;
  int          err_total, checked;

  hbp_host_port DUT (.*);
  hbp_host_model HM (.*);

  assign data_in = (data_out & ~data_oe_n) | (host_d & data_oe_n);
  assign addr_in = (addr_out & ~addr_oe_n) | (host_a & addr_oe_n);

  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input int k, input logic [15:0] a, input logic [15:0] d);
    HM.access(1'b1, k, a, d, rdv);
    @(negedge sys_clk);
  endtask

  task automatic rd(input int k, input logic [15:0] a, input logic [15:0] e);
    HM.access(1'b0, k, a, 16'h0000, rdv);
    chk(rdv, e);
    @(negedge sys_clk);
  endtask

  // Straps {legacy, muxed, order, polarity, style, width}
  task automatic boot(input logic [5:0] s);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    {baud_hi_legacy_strap, muxed_addr_strap, byte_order_strap} <= s[5:3];
    {strobe_polarity_strap, strobe_style_strap, data_width_strap} <= s[2:0];
    repeat (16) @(posedge sys_clk);
    HM.idle();
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #5000000;
    err_total++;
    results();
  end

  initial begin
    sys_clk = 1'b0;
    {rst_n, core_ram_active, rx_push, tx_pop, upper_lane_enable_n} = '0;
    {baud_hi_legacy_strap, baud_lo_strap, muxed_addr_strap, byte_order_strap} = '0;
    {strobe_polarity_strap, strobe_style_strap, data_width_strap} = '0;
    {core_ram_addr, rx_push_data, irq_sources, err_total, checked} = '0;
    boot(6'b000001);
    chk(16'({ram_collision_n, rx_fifo_dma_req, tx_fifo_dma_req}), 16'h0005);
    for (int m = 0; m < 3; m++) begin
      boot({3'b000, m == 2, m > 0, 1'b1});
      wr(0, 16'h0010, 16'h1230 + 16'(m));
      rd(0, 16'h0010, 16'h1230 + 16'(m));
    end
    wr(5, 16'h0010, 16'hDEAD);
    rd(0, 16'h0010, 16'h1232);
    wr(2, 16'h0000, 16'h0003);
    rd(1, 16'h0000, 16'h0000);
    wr(1, 16'h0000, 16'h0003);
    chk(16'(baud_sel_ff), 16'h0001);
    rd(1, 16'h0020, 16'h0000);
    wr(0, 16'h0020, 16'h1111);
    @(posedge sys_clk) upper_lane_enable_n <= 1'b1;
    wr(0, 16'h0020, 16'hABCD);
    @(posedge sys_clk) upper_lane_enable_n <= 1'b0;
    rd(0, 16'h0020, 16'h11CD);
    @(posedge sys_clk) core_ram_active <= 1'b1;
    core_ram_addr <= 11'h008;
    HM.access(1'b0, 0, 16'h0010, 16'h0000, rdv);
    chk(16'(HM.saw_busy), 16'h0001);
    HM.access(1'b0, 0, 16'h0020, 16'h0000, rdv);
    chk(16'(HM.saw_busy), 16'h0000);
    wr(0, 16'h0010, 16'hBEEF);
    chk(16'(HM.saw_busy), 16'h0001);
    @(posedge sys_clk) core_ram_active <= 1'b0;
    rd(0, 16'h0010, 16'h1232);
    wr(1, 16'h0002, 16'h8001);
    wr(1, 16'h0004, 16'h0001);
    @(posedge sys_clk) irq_sources <= 4'h1;
    repeat (3) @(negedge sys_clk);
    chk(16'({irq_out_a, irq_out_b}), 16'h0002);
    @(posedge sys_clk) irq_sources <= 4'h0;
    repeat (3) @(negedge sys_clk);
    chk(16'({irq_out_a, irq_out_b}), 16'h0001);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) rx_push <= 1'b1;
      rx_push_data <= 16'hA5A0 + 16'(i);
    end
    @(posedge sys_clk) rx_push <= 1'b0;
    @(negedge sys_clk);
    chk(16'(rx_fifo_dma_req), 16'h0001);
    rd(3, 16'hFFFF, 16'hA5A0);
    chk(16'(rx_fifo_dma_req), 16'h0001);
    rd(3, 16'hFFFF, 16'hA5A1);
    chk(16'(rx_fifo_dma_req), 16'h0000);
    // Fill the whole transmit FIFO, chip selects idle
    for (int i = 0; i < 8; i++) wr(4, 16'hFFFF, 16'h0B00 + 16'(i));
    chk(16'(tx_fifo_dma_req), 16'h0000);
    @(posedge sys_clk) tx_pop <= 1'b1;
    @(posedge sys_clk) tx_pop <= 1'b0;
    @(negedge sys_clk);
    chk(tx_pop_data_ff, 16'h0B00);
    chk(16'(tx_pop_valid_ff), 16'h0001);
    boot(6'b001000);
    wr(1, 16'h0001, 16'h0003);
    chk(16'(baud_sel_ff), 16'h0001);
    wr(0, 16'h0041, 16'h0012);
    wr(0, 16'h0040, 16'h0034);
    rd(0, 16'h0040, 16'hFF34);
    boot(6'b110001);
    wr(0, 16'h0030, 16'h7777);
    chk(addr_out, 16'h0030);
    chk(addr_oe_n, 16'h0000);
    rd(0, 16'h0030, 16'h7777);
    rd(0, 16'h0040, 16'h3412);
    chk(16'({legacy_mode_ff, baud_sel_ff}), 16'h0006);
    results();
  end
endmodule
